// [shared/fpg_pkg.sv]
// Constants and types for the fuse programming sequencer
package fpg_pkg;
   // Pin level codes, four-valued selection pins
   localparam logic [1:0] LVL_LOW   = 2'h0;
   localparam logic [1:0] LVL_HIGH  = 2'h1;
   localparam logic [1:0] LVL_ELEV  = 2'h2;
   localparam logic [1:0] LVL_FLOAT = 2'h3;

   // Array geometry
   localparam int INPUT_LINES   = 32;
   localparam int PRODUCT_LINES = 64;
   localparam int IN_SEL_W      = 8;
   localparam int PA_W          = 3;
   localparam int PO_W          = 4;

   // Attempt limit per fuse
   localparam logic [2:0] MAX_ATTEMPTS = 3'h4;

   // Step times in ns
   localparam int STEP_NS    = 1000;
   localparam int PULSE_NS   = 10000;
   localparam int VERIFY_NS  = 400;
   localparam int CLK_NS     = 40;
   // Least times round up
   localparam int STEP_CYC   = (STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int VERIFY_CYC = (VERIFY_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W      = 16;

   typedef enum {
      ST_IDLE, ST_ENABLE, ST_INSEL, ST_PASEL, ST_SUPPLY, ST_PULSE,
      ST_SUPPLY_DN, ST_VERIFY, ST_SAMPLE, ST_REL_PO, ST_REL_SEL, ST_REL_EN
   } fpg_state_t;
endpackage : fpg_pkg

// [rtl/fpg_sequencer.sv]
// Host-side sequencer that opens and verifies one array fuse through the device pins
// Notes on behaviour
// - Fuse addressed by one input line then a pulse on one product line.
// - Program enable goes to elevated level before any selection.
// - Input line chosen by half-select and input-line select levels.
// - Product address pins set after input-line selection.
// - Fuse opened by pulsing the one matching product pulse pin elevated.
// - Supply back to normal and readback strobe raised on the same clock edge.
// - Whole sequence repeats on intact fuse only while the security fuse is intact, at most four attempts.
// - Selection pins take low, high, elevated or float levels.
`timescale 1ns/100ps
module fpg_sequencer
   import fpg_pkg::*;
#(
   parameter int STEP_CYCLES   = STEP_CYC,
   parameter int PULSE_CYCLES  = PULSE_CYC,
   parameter int VERIFY_CYCLES = VERIFY_CYC
) (
   // Clock, reset, enable
   input  wire logic                  MCLK,
   input  wire logic                  RST,
   input  wire logic                  CKE,
   // Command
   input  wire logic                  START,
   input  wire logic [4:0]            INPUT_LINE,
   input  wire logic [5:0]            PRODUCT_LINE,
   input  wire logic                  SECURITY_INTACT,
   output logic                       BUSY,
   output logic                       DONE,
   output logic                       OPENED,
   output logic                       NO_READBACK,
   output logic [2:0]                 ATTEMPTS,
   // Device pins, two bits per select, address and pulse pin as level code; enable, supply, strobe and sense one bit
   output logic                       PROGRAM_MODE_ENTRY_PIN,
   output logic                       SUPPLY_ELEVATED,
   output logic                       READBACK_STROBE_PIN,
   output logic [2*IN_SEL_W-1:0]      INPUT_LINE_SELECT_PINS,
   output logic [1:0]                 HALF_SELECT_PIN,
   output logic [2*PA_W-1:0]          PRODUCT_ADDRESS_PINS,
   output logic [2*PO_W-1:0]          PRODUCT_PULSE_PINS,
   input  wire logic [PO_W-1:0]       PRODUCT_PULSE_IN
);

   fpg_state_t        state_r;
   logic [TMR_W-1:0]  tmr_r;
   logic [4:0]        in_line_r;
   logic [5:0]        pr_line_r;
   logic              secure_r;
   logic              tmr_done;
   logic              rearm_r;
   logic              retry;

   assign tmr_done = (tmr_r == '0);
   // Another attempt for an intact fuse
   assign retry = !OPENED && secure_r && (ATTEMPTS < MAX_ATTEMPTS);

   // Input-line select encoding
   function automatic logic [2*IN_SEL_W-1:0] in_sel_enc(input logic [4:0] n);
      logic [2*IN_SEL_W-1:0] v;
      v = '0;
      for (int i = 0; i < IN_SEL_W; i++) begin
         v[2*i +: 2] = LVL_ELEV;
      end
      v[2*n[4:2] +: 2] = n[0] ? LVL_HIGH : LVL_LOW;
      return v;
   endfunction : in_sel_enc

   // Product address encoding
   function automatic logic [2*PA_W-1:0] pa_enc(input logic [5:0] n);
      logic [2*PA_W-1:0] v;
      v = '0;
      for (int i = 0; i < PA_W; i++) begin
         v[2*i +: 2] = n[i] ? LVL_ELEV : LVL_FLOAT;
      end
      return v;
   endfunction : pa_enc

   // Product pulse pin index for a line
   function automatic logic [1:0] po_idx(input logic [5:0] n);
      return 2'h3 - n[4:3];
   endfunction : po_idx

   function automatic logic [TMR_W-1:0] cyc(input int c);
      return TMR_W'((c < 1) ? 0 : c - 1);
   endfunction : cyc

   // Sequence and timer
   always_ff @(posedge MCLK) begin
      if (RST) begin
         state_r <= ST_IDLE;
         tmr_r   <= '0;
      end else if (CKE) begin
         if (!tmr_done) begin
            tmr_r <= tmr_r - 1'b1;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  if (START) begin
                     state_r <= ST_ENABLE;
                     tmr_r   <= cyc(STEP_CYCLES);
                  end
               end
               // A retry first raises the enable again
               ST_ENABLE: begin
                  if (!rearm_r) begin
                     state_r <= ST_INSEL;
                  end
                  tmr_r <= cyc(STEP_CYCLES);
               end
               ST_INSEL:     begin state_r <= ST_PASEL;     tmr_r <= cyc(STEP_CYCLES);   end
               ST_PASEL:     begin state_r <= ST_SUPPLY;    tmr_r <= cyc(STEP_CYCLES);   end
               ST_SUPPLY:    begin state_r <= ST_PULSE;     tmr_r <= cyc(PULSE_CYCLES);  end
               ST_PULSE:     begin state_r <= ST_SUPPLY_DN; tmr_r <= cyc(STEP_CYCLES);   end
               ST_SUPPLY_DN: begin state_r <= ST_VERIFY;    tmr_r <= cyc(VERIFY_CYCLES); end
               ST_VERIFY:    begin state_r <= ST_SAMPLE;    tmr_r <= '0;                 end
               ST_SAMPLE:    begin state_r <= ST_REL_PO;    tmr_r <= cyc(STEP_CYCLES);   end
               ST_REL_PO:    begin state_r <= ST_REL_SEL;   tmr_r <= cyc(STEP_CYCLES);   end
               ST_REL_SEL:   begin state_r <= ST_REL_EN;    tmr_r <= cyc(STEP_CYCLES);   end
               ST_REL_EN: begin
                  if (retry) begin
                     state_r <= ST_ENABLE;
                     tmr_r   <= cyc(STEP_CYCLES);
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Command capture
   always_ff @(posedge MCLK) begin
      if (RST) begin
         in_line_r <= '0;
         pr_line_r <= '0;
         secure_r  <= 1'b0;
      end else if (CKE && state_r == ST_IDLE && START) begin
         in_line_r <= INPUT_LINE;
         pr_line_r <= PRODUCT_LINE;
         secure_r  <= SECURITY_INTACT;
      end
   end

   // Retry marker, enable drops and rises again
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rearm_r <= 1'b0;
      end else if (CKE && tmr_done) begin
         if (state_r == ST_REL_EN) begin
            rearm_r <= retry;
         end else if (state_r == ST_ENABLE) begin
            rearm_r <= 1'b0;
         end
      end
   end

   // Status
   always_ff @(posedge MCLK) begin
      if (RST) begin
         BUSY        <= 1'b0;
         DONE        <= 1'b0;
         OPENED      <= 1'b0;
         NO_READBACK <= 1'b0;
         ATTEMPTS    <= '0;
      end else if (CKE) begin
         DONE <= 1'b0;
         if (state_r == ST_IDLE && START) begin
            BUSY        <= 1'b1;
            OPENED      <= 1'b0;
            NO_READBACK <= !SECURITY_INTACT;
            ATTEMPTS    <= 3'h1;
         end else if (tmr_done && state_r == ST_SAMPLE) begin
            // Low on pulsed pin means open
            // Without security fuse the result is not trusted
            OPENED <= secure_r ? !PRODUCT_PULSE_IN[po_idx(pr_line_r)] : 1'b0;
         end else if (tmr_done && state_r == ST_REL_EN) begin
            if (retry) begin
               ATTEMPTS <= ATTEMPTS + 3'h1;
            end else begin
               BUSY <= 1'b0;
               DONE <= 1'b1;
            end
         end
      end
   end

   // Pin drive
   always_ff @(posedge MCLK) begin
      if (RST) begin
         PROGRAM_MODE_ENTRY_PIN <= 1'b0;
         SUPPLY_ELEVATED        <= 1'b0;
         READBACK_STROBE_PIN    <= 1'b0;
         INPUT_LINE_SELECT_PINS <= {IN_SEL_W{LVL_FLOAT}};
         HALF_SELECT_PIN        <= LVL_FLOAT;
         PRODUCT_ADDRESS_PINS   <= {PA_W{LVL_FLOAT}};
         PRODUCT_PULSE_PINS     <= {PO_W{LVL_FLOAT}};
      end else if (CKE && tmr_done) begin
         case (state_r)
            ST_IDLE: begin
               if (START) begin
                  PROGRAM_MODE_ENTRY_PIN <= 1'b1;
               end
            end
            ST_ENABLE: begin
               if (rearm_r) begin
                  PROGRAM_MODE_ENTRY_PIN <= 1'b1;
               end else begin
                  INPUT_LINE_SELECT_PINS <= in_sel_enc(in_line_r);
                  HALF_SELECT_PIN        <= in_line_r[1] ? LVL_ELEV : LVL_FLOAT;
               end
            end
            ST_INSEL: PRODUCT_ADDRESS_PINS <= pa_enc(pr_line_r);
            ST_PASEL: SUPPLY_ELEVATED <= 1'b1;
            // One input line, one product line
            ST_SUPPLY: PRODUCT_PULSE_PINS[2*po_idx(pr_line_r) +: 2] <= LVL_ELEV;
            ST_PULSE: PRODUCT_PULSE_PINS <= {PO_W{LVL_FLOAT}};
            ST_SUPPLY_DN: begin
               SUPPLY_ELEVATED     <= 1'b0;
               READBACK_STROBE_PIN <= 1'b1;
            end
            ST_SAMPLE: READBACK_STROBE_PIN <= 1'b0;
            ST_REL_PO: PRODUCT_ADDRESS_PINS <= {PA_W{LVL_FLOAT}};
            ST_REL_SEL: begin
               INPUT_LINE_SELECT_PINS <= {IN_SEL_W{LVL_FLOAT}};
               HALF_SELECT_PIN        <= LVL_FLOAT;
            end
            ST_REL_EN: PROGRAM_MODE_ENTRY_PIN <= 1'b0;
            default: ;
         endcase
      end
   end

   // Supply never elevated outside enable
   enable_before_supply_a: assert property (@(posedge MCLK) disable iff (RST)
      SUPPLY_ELEVATED |-> PROGRAM_MODE_ENTRY_PIN)
      else $error("supply elevated without program enable");

   pulse_needs_supply_a: assert property (@(posedge MCLK) disable iff (RST)
      (PRODUCT_PULSE_PINS != {PO_W{LVL_FLOAT}}) |-> SUPPLY_ELEVATED)
      else $error("product pulse without elevated supply");

   strobe_at_normal_a: assert property (@(posedge MCLK) disable iff (RST)
      READBACK_STROBE_PIN |-> !SUPPLY_ELEVATED)
      else $error("readback strobe with elevated supply");

   select_before_pulse_a: assert property (@(posedge MCLK) disable iff (RST)
      SUPPLY_ELEVATED |-> (INPUT_LINE_SELECT_PINS != {IN_SEL_W{LVL_FLOAT}}))
      else $error("supply raised before input selection");

   attempt_limit_a: assert property (@(posedge MCLK) disable iff (RST)
      ATTEMPTS <= MAX_ATTEMPTS)
      else $error("more than four attempts");

   secure_readback_a: assert property (@(posedge MCLK) disable iff (RST)
      NO_READBACK |-> !OPENED)
      else $error("open reported without readback");

   release_order_a: assert property (@(posedge MCLK) disable iff (RST)
      $fell(PROGRAM_MODE_ENTRY_PIN) |-> (INPUT_LINE_SELECT_PINS == {IN_SEL_W{LVL_FLOAT}})
         && (PRODUCT_ADDRESS_PINS == {PA_W{LVL_FLOAT}}))
      else $error("enable released before selections");

   one_pulse_pin_a: assert property (@(posedge MCLK) disable iff (RST)
      (PRODUCT_PULSE_PINS != {PO_W{LVL_FLOAT}}) |->
         ($countones({PRODUCT_PULSE_PINS[7:6] == LVL_ELEV, PRODUCT_PULSE_PINS[5:4] == LVL_ELEV,
                      PRODUCT_PULSE_PINS[3:2] == LVL_ELEV,
                      PRODUCT_PULSE_PINS[1:0] == LVL_ELEV}) == 1)
         && ($countones(PRODUCT_PULSE_PINS) == 2*PO_W - 1))
      else $error("not exactly one product pulse pin elevated");

   done_pulse_a: assert property (@(posedge MCLK) disable iff (RST)
      DONE && CKE |=> !DONE)
      else $error("done held longer than one cycle");

endmodule : fpg_sequencer

// [tb/fpg_device_model.sv]
// Behavioural fuse array device driven through its programming pins
`timescale 1ns/100ps
module fpg_device_model
   import fpg_pkg::*;
(
   // Clock and test controls
   input  wire logic              clk,
   input  wire logic              clr,
   input  wire logic              sec,
   input  wire logic [2:0]        need,
   // Programming pins
   input  wire logic              mode_pin,
   input  wire logic              supply_pin,
   input  wire logic              strobe_pin,
   input  wire logic [2*PO_W-1:0] pulse_pins,
   output logic [PO_W-1:0]        sense
);
   int              pulses = 0;
   int              hit    = 0;
   logic            on_q   = 1'b0;
   logic [PO_W-1:0] noise  = 4'h0;
   logic            on;
   // One pulse pin at elevated level
   assign on = pulse_pins !== {PO_W{LVL_FLOAT}};
   // Pulses count only in program mode with supply up
   always @(posedge clk) begin
      noise <= noise + 4'h7;
      on_q  <= on;
      if (clr)
         pulses <= 0;
      else if (on && !on_q && mode_pin && supply_pin) begin
         pulses <= pulses + 1;
         for (int i = 0; i < PO_W; i++)
            if (pulse_pins[2*i +: 2] === LVL_ELEV) hit <= i;
      end
   end
   always_comb begin
      sense = noise;
      if (strobe_pin && mode_pin && sec) sense[hit] = pulses < int'(need);
   end
endmodule : fpg_device_model

// [tb/fpg_sequencer_tb.sv]
// Self-checking bench for the fuse programming sequencer
`timescale 1ns/100ps
module fpg_sequencer_tb
   import fpg_pkg::*;
;
   logic MCLK = 0, RST = 1, CKE = 1, START = 0, SEC = 1, clr = 0;
   logic [4:0] INPUT_LINE = 0;
   logic [5:0] PRODUCT_LINE = 0;
   logic [2:0] need = 1, ATTEMPTS;
   logic BUSY, DONE, OPENED, NO_READBACK, PMODE, SUP, STRB, po_on_q, st_q;
   logic [15:0] INPUT_LINE_SELECT_PINS;
   logic [1:0]  HALF_SELECT_PIN;
   logic [5:0]  PRODUCT_ADDRESS_PINS;
   logic [7:0]  PRODUCT_PULSE_PINS;
   logic [3:0]  PRODUCT_PULSE_IN;
   int n_mismatch = 0, samples_checked = 0, n_pulse, n_strobe, ea, eo, pc, t;
   always #20 MCLK = ~MCLK;
   fpg_sequencer #(.STEP_CYCLES(2), .PULSE_CYCLES(3), .VERIFY_CYCLES(2)) i_fpg_sequencer (
      .MCLK(MCLK), .RST(RST), .CKE(CKE), .START(START), .INPUT_LINE(INPUT_LINE),
      .PRODUCT_LINE(PRODUCT_LINE), .SECURITY_INTACT(SEC), .BUSY(BUSY), .DONE(DONE),
      .OPENED(OPENED), .NO_READBACK(NO_READBACK), .ATTEMPTS(ATTEMPTS),
      .PROGRAM_MODE_ENTRY_PIN(PMODE), .SUPPLY_ELEVATED(SUP), .READBACK_STROBE_PIN(STRB),
      .INPUT_LINE_SELECT_PINS(INPUT_LINE_SELECT_PINS), .HALF_SELECT_PIN(HALF_SELECT_PIN),
      .PRODUCT_ADDRESS_PINS(PRODUCT_ADDRESS_PINS), .PRODUCT_PULSE_PINS(PRODUCT_PULSE_PINS),
      .PRODUCT_PULSE_IN(PRODUCT_PULSE_IN));
   fpg_device_model i_fpg_device_model (
      .clk(MCLK), .clr(clr), .sec(SEC), .need(need), .mode_pin(PMODE), .supply_pin(SUP),
      .strobe_pin(STRB), .pulse_pins(PRODUCT_PULSE_PINS), .sense(PRODUCT_PULSE_IN));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   task automatic chk_rel();
      chk("rel_pp", {PRODUCT_ADDRESS_PINS, PRODUCT_PULSE_PINS, HALF_SELECT_PIN}, 16'hFFFF);
      chk("rel_sel", INPUT_LINE_SELECT_PINS, 16'hFFFF);
      chk("rel_lvl", {12'h0, BUSY, PMODE, SUP, STRB}, 16'h0);
   endtask : chk_rel
   function automatic logic [15:0] exp_sel(input logic [4:0] n);
      logic [15:0] v;
      v = {8{LVL_ELEV}};
      v[2*n[4:2] +: 2] = n[0] ? LVL_HIGH : LVL_LOW;
      return v;
   endfunction : exp_sel
   function automatic logic [15:0] exp_pp(input logic [4:0] n, input logic [5:0] p);
      logic [15:0] v;
      v = 16'hFFFF;
      for (int i = 0; i < 3; i++)
         if (p[i]) v[10+2*i +: 2] = LVL_ELEV;
      v[2+2*(3-p[4:3]) +: 2] = LVL_ELEV;
      if (n[1]) v[1:0] = LVL_ELEV;
      return v;
   endfunction : exp_pp
   // Pin watch at each fuse pulse and readback strobe
   always @(negedge MCLK) begin
      po_on_q <= PRODUCT_PULSE_PINS !== 8'hFF;
      st_q    <= STRB;
      if (BUSY === 1'b1 && PRODUCT_PULSE_PINS !== 8'hFF && po_on_q === 1'b0) begin
         n_pulse++;
         chk("mode_sup", {14'h0, PMODE, SUP}, 16'h3);
         chk("in_sel", INPUT_LINE_SELECT_PINS, exp_sel(INPUT_LINE));
         chk("pa_po_half", {PRODUCT_ADDRESS_PINS, PRODUCT_PULSE_PINS, HALF_SELECT_PIN},
             exp_pp(INPUT_LINE, PRODUCT_LINE));
      end
      if (STRB === 1'b1 && st_q === 1'b0) begin
         n_strobe++;
         chk("sup_at_strobe", {14'h0, PMODE, SUP}, 16'h2);
      end
   end
   always @(posedge MCLK) CKE <= $urandom_range(7) != 0;
   initial begin
      repeat (20000) @(posedge MCLK);
      n_mismatch++;
      end_sim();
   end
   initial begin
      void'($urandom(32'h2476));
      repeat (20) @(posedge MCLK);
      RST <= 1'b0;
      @(negedge MCLK);
      chk_rel();
      for (int k = 0; k < 12; k++) begin
         @(posedge MCLK);
         INPUT_LINE <= 5'($urandom);
         PRODUCT_LINE <= 6'($urandom);
         need <= 3'($urandom_range(5, 1));
         SEC <= k % 3 != 2;
         clr <= 1'b1;
         @(posedge MCLK);
         clr <= 1'b0;
         START <= 1'b1;
         @(negedge MCLK);
         n_pulse = 0;
         n_strobe = 0;
         for (t = 0; t < 100 && BUSY !== 1'b1; t++) @(negedge MCLK);
         @(posedge MCLK);
         START <= 1'b0;
         repeat (3) @(posedge MCLK);
         START <= 1'b1;
         @(posedge MCLK);
         START <= 1'b0;
         for (t = 0; t < 3000 && DONE !== 1'b1; t++) @(negedge MCLK);
         ea = 0;
         pc = 0;
         eo = 0;
         do begin
            ea++;
            pc++;
            eo = SEC && pc >= need;
         end while (SEC && !eo && ea < int'(MAX_ATTEMPTS));
         chk("done", {15'h0, DONE}, 16'h1);
         chk("attempts", {13'h0, ATTEMPTS}, 16'(ea));
         chk("pulses", 16'(n_pulse), 16'(ea));
         chk("strobes", 16'(n_strobe), 16'(ea));
         chk("opened", {15'h0, OPENED}, 16'(eo));
         chk("no_readback", {15'h0, NO_READBACK}, {15'h0, !SEC});
         chk_rel();
      end
      end_sim();
   end
endmodule : fpg_sequencer_tb
